/* File: pkg/bgl_consts.svh */
// Constants for the brownout gain level control block.
// Assumes a 25 MHz system clock and a 32-bit classic Wishbone slave.
`ifndef BGL_CONSTS_SVH
`define BGL_CONSTS_SVH

// ****************************************
// Register indices (byte address = index * 4)
// ****************************************
`define BGL_IDX_ATKREL   8'h20
`define BGL_IDX_RELMAX   8'h21
`define BGL_IDX_THRESH   8'h22
`define BGL_IDX_HOLDSTAT 8'h23
`define BGL_IDX_LVL2     8'h24
`define BGL_IDX_CTRL     8'h30
`define BGL_IDX_ATTEN    8'h31

// ****************************************
// Reset values and writable bit masks
// ****************************************
`define BGL_RST_ATKREL   8'h06
`define BGL_RST_RELMAX   8'h2C
`define BGL_RST_THRESH   8'h4C
`define BGL_RST_HOLDSTAT 8'h20
`define BGL_RST_LVL2     8'h02
`define BGL_RST_CTRL     8'h10
`define BGL_WM_ATKREL    8'hFE
`define BGL_WM_HOLD      8'hF0
`define BGL_WM_LVL2      8'hFE
`define BGL_WM_CTRL      8'hFB
`define BGL_HOLDCLR_BIT  2

// ****************************************
// Threshold validity limits per source, infinite hold code and last step code
// ****************************************
`define BGL_THR_MAX_BAT  8'h38
`define BGL_THR_MAX_PVS  8'hD2
`define BGL_HOLD_INF     3'h7
`define BGL_STEP_LAST    4'hF

// ****************************************
// Timing
// ****************************************
`define BGL_CLK_MHZ      25
`define BGL_ATK_BASE_NS  2500
`define BGL_ATK_BASE_CYC ((`BGL_ATK_BASE_NS * `BGL_CLK_MHZ + 999) / 1000)
`define BGL_MS_US        1000
`define BGL_MS_CYC       (`BGL_MS_US * `BGL_CLK_MHZ)

`endif

/* File: pkg/bgl_pkg.sv */
// Types for the brownout gain level control block.
// Assumes bgl_consts.svh supplies the numeric constants.
`default_nettype none

package bgl_pkg;

    // ****************************************
    // Controller states, one-hot
    // ****************************************
    typedef enum logic [3:0] {
        BGL_IDLE    = 4'b0001,
        BGL_ATTACK  = 4'b0010,
        BGL_HOLD    = 4'b0100,
        BGL_RELEASE = 4'b1000
    } bgl_state_t;

    // ****************************************
    // Register layouts
    // ****************************************
    typedef struct packed {
        logic [2:0] atkRate;
        logic [3:0] relStep;
        logic       rsv;
    } bgl_atkrel_t;

    typedef struct packed {
        logic [2:0] relRate;
        logic [4:0] maxAtten;
    } bgl_relmax_t;

    typedef struct packed {
        logic [2:0] holdTime;
        logic       disable3;
        logic [3:0] stateRo;
    } bgl_hold_t;

    typedef struct packed {
        logic [2:0] dwell;
        logic [3:0] atkStep;
        logic       rsv;
    } bgl_lvl2_t;

    typedef struct packed {
        logic [3:0] lvl3AtkStep;
        logic       snapHold;
        logic       holdClear;
        logic       srcSel;
        logic       globalEn;
    } bgl_ctrl_t;

endpackage

`default_nettype wire

/* File: rtl/bgl_tick_gen.sv */
// Free-running divider giving a one-cycle tick every DIV clocks.
// Assumes a synchronous active-low reset.
`default_nettype none

module bgl_tick_gen #(
    parameter int DIV = 25
) (
    // Clock and reset
    input  wire logic sys_clk,
    input  wire logic rst_n,
    // Tick out
    output logic      tick
);
    localparam int W = $clog2(DIV + 1);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] cntFf;
    logic [W-1:0] nxt_cnt;

    // ****************************************
    // Counter
    // ****************************************
    assign tick    = (cntFf == LAST);
    assign nxt_cnt = tick ? '0 : cntFf + W'(1);

    // Wraps at DIV-1
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            cntFf <= '0;
        end else begin
            cntFf <= nxt_cnt;
        end
    end
endmodule

`default_nettype wire

/* File: rtl/bgl_brownout_ctrl.sv */
// Level-3 brownout controller with register file on classic Wishbone.
// Assumes supplyCode is synchronous and scaled like the selected threshold.
`include "bgl_consts.svh"
`default_nettype none

module bgl_brownout_ctrl #(
    parameter int MS_CYCLES = `BGL_MS_CYC
) (
    // Clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rst_n,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [9:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Supply measurement
    input  wire logic [7:0]  supplyCode,
    // Gain control
    output logic      [18:0] gainAtten,
    output logic      [3:0]  controllerState,
    // Level-2 settings for the level-2 engine
    output logic      [13:0] lvl2DwellUs,
    output logic      [18:0] lvl2AttackStep
);
    // ****************************************
    // Decode tables (attenuation in 0.1 mdB)
    // ****************************************
    // Step sizes share one table for attack and release
    function automatic logic [18:0] stepSize(input logic [3:0] c);
        logic [18:0] s;
        s = 19'd5000 + 19'(c - 4'd1) * 19'd3958;
        if (c == 4'h0) s = 19'd625;
        if (c == `BGL_STEP_LAST) s = 19'd60000;
        return s;
    endfunction

    // Attack interval in 2.5 us ticks
    function automatic logic [10:0] atkTicks(input logic [2:0] c);
        logic [10:0] t;
        case (c)
            3'd0: t = 11'd1;
            3'd1: t = 11'd2;
            3'd2: t = 11'd4;
            3'd3: t = 11'd10;
            3'd4: t = 11'd20;
            3'd5: t = 11'd40;
            3'd6: t = 11'd100;
            default: t = 11'd200;
        endcase
        return t;
    endfunction

    // Release interval in ms
    function automatic logic [10:0] relMs(input logic [2:0] c);
        logic [10:0] t;
        case (c)
            3'd0: t = 11'd5;
            3'd1: t = 11'd10;
            3'd2: t = 11'd25;
            3'd3: t = 11'd50;
            3'd4: t = 11'd100;
            3'd5: t = 11'd250;
            3'd6: t = 11'd500;
            default: t = 11'd1000;
        endcase
        return t;
    endfunction

    // Hold time in ms, code 7 handled apart
    function automatic logic [10:0] holdMs(input logic [2:0] c);
        logic [10:0] t;
        case (c)
            3'd0: t = 11'd0;
            3'd1: t = 11'd10;
            3'd2: t = 11'd100;
            3'd3: t = 11'd250;
            3'd4: t = 11'd500;
            3'd5: t = 11'd1000;
            default: t = 11'd2000;
        endcase
        return t;
    endfunction

    // Level-2 dwell in us
    function automatic logic [13:0] dwellUs(input logic [2:0] c);
        logic [13:0] t;
        case (c)
            3'd0: t = 14'd0;
            3'd1: t = 14'd100;
            3'd2: t = 14'd250;
            3'd3: t = 14'd500;
            3'd4: t = 14'd1000;
            3'd5: t = 14'd2000;
            3'd6: t = 14'd4000;
            default: t = 14'd8000;
        endcase
        return t;
    endfunction

    // ****************************************
    // Registers
    // ****************************************
    bgl_pkg::bgl_atkrel_t atkRelFf;
    bgl_pkg::bgl_relmax_t relMaxFf;
    logic [7:0]           thrFf;
    bgl_pkg::bgl_hold_t   holdFf;
    bgl_pkg::bgl_lvl2_t   lvl2Ff;
    bgl_pkg::bgl_ctrl_t   ctrlFf;
    logic                 ackFf;
    logic [31:0]          datFf;
    bgl_pkg::bgl_state_t  stateFf;
    bgl_pkg::bgl_state_t  nxt_state;
    logic [18:0]          attenFf;
    logic [18:0]          nxt_atten;
    logic [10:0]          cntFf;
    logic [10:0]          nxt_cnt;
    logic [3:0]           shownFf;

    // ****************************************
    // Bus decode
    // ****************************************
    wire logic       req     = wb_cyc_i & wb_stb_i;
    wire logic [7:0] idx     = wb_adr_i[9:2];
    wire logic       wrStb   = req & wb_we_i & ackFf & wb_sel_i[0];
    wire logic [7:0] wd      = wb_dat_i[7:0];
    wire logic       hitAr   = (idx == `BGL_IDX_ATKREL);
    wire logic       hitRm   = (idx == `BGL_IDX_RELMAX);
    wire logic       hitTh   = (idx == `BGL_IDX_THRESH);
    wire logic       hitHs   = (idx == `BGL_IDX_HOLDSTAT);
    wire logic       hitL2   = (idx == `BGL_IDX_LVL2);
    wire logic       hitCt   = (idx == `BGL_IDX_CTRL);
    wire logic       hitAt   = (idx == `BGL_IDX_ATTEN);
    wire logic       holdClr = wrStb & hitCt & wd[`BGL_HOLDCLR_BIT];

    // Read mux; unmapped and reserved bits read zero
    wire logic [31:0] rdMux =
        hitAr ? {24'h0, atkRelFf & `BGL_WM_ATKREL} :
        hitRm ? {24'h0, relMaxFf} :
        hitTh ? {24'h0, thrFf} :
        hitHs ? {24'h0, holdFf.holdTime, holdFf.disable3, shownFf} :
        hitL2 ? {24'h0, lvl2Ff & `BGL_WM_LVL2} :
        hitCt ? {24'h0, ctrlFf & `BGL_WM_CTRL} :
        hitAt ? {13'h0, attenFf} : 32'h0000_0000;

    // One wait cycle; writes commit on the ack edge
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ackFf <= 1'b0;
            datFf <= 32'h0000_0000;
        end else begin
            ackFf <= req & ~ackFf;
            datFf <= rdMux;
        end
    end

    // Register writes, masked so reserved bits stay zero
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            atkRelFf <= `BGL_RST_ATKREL;
            relMaxFf <= `BGL_RST_RELMAX;
            thrFf    <= `BGL_RST_THRESH;
            holdFf   <= `BGL_RST_HOLDSTAT;
            lvl2Ff   <= `BGL_RST_LVL2;
            ctrlFf   <= `BGL_RST_CTRL;
        end else begin
            if (wrStb && hitAr) atkRelFf <= wd & `BGL_WM_ATKREL;
            if (wrStb && hitRm) relMaxFf <= wd;
            if (wrStb && hitTh) thrFf <= wd;
            if (wrStb && hitHs) holdFf <= wd & `BGL_WM_HOLD;
            if (wrStb && hitL2) lvl2Ff <= wd & `BGL_WM_LVL2;
            if (wrStb && hitCt) ctrlFf <= wd & `BGL_WM_CTRL;
        end
    end

    assign wb_ack_o = ackFf;
    assign wb_dat_o = datFf;

    // ****************************************
    // Time bases
    // ****************************************
    logic tickAtk;
    logic tickMs;

    bgl_tick_gen #(.DIV(`BGL_ATK_BASE_CYC)) uAtkTick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (tickAtk)
    );

    bgl_tick_gen #(.DIV(MS_CYCLES)) uMsTick (
        .sys_clk (sys_clk),
        .rst_n   (rst_n),
        .tick    (tickMs)
    );

    // ****************************************
    // Supply compare and settings
    // ****************************************
    // Out-of-range codes mean zero volts, so they never trip
    wire logic thrMax   = ctrlFf.srcSel ? (thrFf <= `BGL_THR_MAX_PVS)
                                        : (thrFf <= `BGL_THR_MAX_BAT);
    wire logic below    = thrMax & (supplyCode < thrFf);
    wire logic active   = ctrlFf.globalEn & ~holdFf.disable3;
    wire logic [18:0] maxA = 19'(relMaxFf.maxAtten) * 19'd10000;
    wire logic [18:0] aStep = stepSize(ctrlFf.lvl3AtkStep);
    wire logic [18:0] rStep = stepSize(atkRelFf.relStep);
    wire logic [10:0] aTgt  = atkTicks(atkRelFf.atkRate);
    wire logic [10:0] rTgt  = relMs(relMaxFf.relRate);
    wire logic [10:0] hTgt  = holdMs(holdFf.holdTime);
    wire logic        hInf  = (holdFf.holdTime == `BGL_HOLD_INF);
    wire logic [10:0] cntUp = cntFf + 11'd1;
    wire logic [19:0] aSum  = {1'b0, attenFf} + {1'b0, aStep};

    // ****************************************
    // State machine
    // ****************************************
    // Hold counts only while supply is fine, so a long dip does not
    // fall straight into release and back into attack.
    always_comb begin
        nxt_state = stateFf;
        nxt_atten = attenFf;
        nxt_cnt   = cntFf;
        case (stateFf)
            bgl_pkg::BGL_IDLE: begin
                nxt_cnt = 11'd0;
                if (active && below) nxt_state = bgl_pkg::BGL_ATTACK;
            end
            bgl_pkg::BGL_ATTACK: begin
                if (!below || attenFf >= maxA) begin
                    nxt_state = bgl_pkg::BGL_HOLD;
                    nxt_cnt   = 11'd0;
                end else if (tickAtk) begin
                    nxt_cnt = cntUp;
                    if (cntUp >= aTgt) begin
                        nxt_cnt   = 11'd0;
                        nxt_atten = (aSum >= {1'b0, maxA}) ? maxA : aSum[18:0];
                    end
                end
            end
            bgl_pkg::BGL_HOLD: begin
                if (below && attenFf < maxA) begin
                    nxt_state = bgl_pkg::BGL_ATTACK;
                    nxt_cnt   = 11'd0;
                end else if (below) begin
                    nxt_cnt = 11'd0;
                end else if (hInf) begin
                    if (holdClr) nxt_state = bgl_pkg::BGL_RELEASE;
                end else if (cntFf >= hTgt) begin
                    nxt_state = bgl_pkg::BGL_RELEASE;
                    nxt_cnt   = 11'd0;
                end else if (tickMs) begin
                    nxt_cnt = cntUp;
                end
            end
            bgl_pkg::BGL_RELEASE: begin
                if (below) begin
                    nxt_state = bgl_pkg::BGL_ATTACK;
                    nxt_cnt   = 11'd0;
                end else if (attenFf == 19'd0) begin
                    nxt_state = bgl_pkg::BGL_IDLE;
                end else if (tickMs) begin
                    nxt_cnt = cntUp;
                    if (cntUp >= rTgt) begin
                        nxt_cnt   = 11'd0;
                        nxt_atten = (attenFf > rStep) ? attenFf - rStep : 19'd0;
                    end
                end
            end
            default: begin
                nxt_state = bgl_pkg::BGL_IDLE;
            end
        endcase
        // Disabled level or function drops all attenuation at once
        if (!active) begin
            nxt_state = bgl_pkg::BGL_IDLE;
            nxt_atten = 19'd0;
            nxt_cnt   = 11'd0;
        end
    end

    // State code for readback
    wire logic [3:0] stCode =
        (stateFf == bgl_pkg::BGL_ATTACK)  ? 4'h1 :
        (stateFf == bgl_pkg::BGL_HOLD)    ? 4'h5 :
        (stateFf == bgl_pkg::BGL_RELEASE) ? 4'h9 : 4'h0;

    // Controller registers and frozen snapshot
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            stateFf <= bgl_pkg::BGL_IDLE;
            attenFf <= 19'd0;
            cntFf   <= 11'd0;
            shownFf <= 4'h0;
        end else begin
            stateFf <= nxt_state;
            attenFf <= nxt_atten;
            cntFf   <= nxt_cnt;
            if (!ctrlFf.snapHold) shownFf <= stCode;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // Level-2 fields decoded for the level-2 engine
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            lvl2DwellUs    <= 14'd0;
            lvl2AttackStep <= 19'd0;
        end else begin
            lvl2DwellUs    <= dwellUs(lvl2Ff.dwell);
            lvl2AttackStep <= stepSize(lvl2Ff.atkStep);
        end
    end

    assign gainAtten       = attenFf;
    assign controllerState = shownFf;
endmodule

`default_nettype wire

/* File: dv/bgl_brownout_ctrl_sva.sv */
// Port checker for the brownout controller.
// Assumes a bind to bgl_brownout_ctrl; one clock, sync reset.
`default_nettype none

module bgl_brownout_ctrl_sva (
    // Clock and reset
    input wire logic        sys_clk,
    input wire logic        rst_n,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [9:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Gain side
    input wire logic [18:0] gainAtten,
    input wire logic [3:0]  controllerState,
    input wire logic [13:0] lvl2DwellUs,
    input wire logic [18:0] lvl2AttackStep
);
    timeunit 1ns;
    timeprecision 1ps;

    // ****
    // Shadow registers
    // ****
    localparam logic [13:0] DWELL [8] = '{0, 100, 250, 500, 1000, 2000, 4000, 8000};
    wire logic       wr  = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];
    wire logic [7:0] idx = wb_adr_i[9:2];
    logic [7:0] ctrl_ff, holdCfg_ff, relMax_ff, lvl2_ff;
    // Freeze and disable spoil gain relations, so gate on both
    wire logic act = ctrl_ff[0] && !holdCfg_ff[4] && !ctrl_ff[3];
    wire logic off = !ctrl_ff[0] || holdCfg_ff[4];

    function automatic int stepOf(input logic [3:0] c);
        return (c == 0) ? 625 : (c == 15) ? 60000 : 5000 + (c - 1) * 3958;
    endfunction

    // Track writes at the ack edge, as the slave does
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            ctrl_ff    <= 8'h10;
            holdCfg_ff <= 8'h20;
            relMax_ff  <= 8'h2C;
            lvl2_ff    <= 8'h02;
        end else if (wr) begin
            if (idx == 8'h30) ctrl_ff <= wb_dat_i[7:0];
            if (idx == 8'h23) holdCfg_ff <= wb_dat_i[7:0];
            if (idx == 8'h21) relMax_ff <= wb_dat_i[7:0];
            if (idx == 8'h24) lvl2_ff <= wb_dat_i[7:0];
        end
    end

    // ****
    // Properties
    // ****
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    ack_after_req_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing after request");
    ack_one_cycle_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    upper_zero_a: assert property (wb_ack_o && !wb_we_i && idx != 8'h31 |-> wb_dat_o[31:8] == '0)
        else $error("upper read bits not zero");
    state_code_a: assert property (controllerState inside {4'h0, 4'h1, 4'h5, 4'h9})
        else $error("state code not legal");
    off_zero_a: assert property (off |=> gainAtten == '0)
        else $error("gain not zero while off");
    idle_zero_a: assert property (act && $past(act) && controllerState == 4'h0 |-> gainAtten == '0)
        else $error("idle with gain applied");
    hold_still_a: assert property (act && $past(act) && $past(act, 2) && controllerState == 4'h5
        && $past(controllerState) == 4'h5 |-> $stable(gainAtten))
        else $error("gain moved during hold");
    cap_hold_a: assert property (act && controllerState == 4'h5 |-> gainAtten <= relMax_ff[4:0] * 10000)
        else $error("gain above cap in hold");
    dwell_dec_a: assert property ($past(rst_n) |-> lvl2DwellUs == DWELL[$past(lvl2_ff[7:5])])
        else $error("dwell decode wrong");
    step_dec_a: assert property ($past(rst_n) |-> lvl2AttackStep == stepOf($past(lvl2_ff[4:1])))
        else $error("attack step decode wrong");
endmodule

`default_nettype wire

/* File: dv/tb_bgl_brownout_ctrl.sv */
// Self-checking bench for the brownout controller.
// Assumes design, package header and checker are compiled first.
`include "bgl_consts.svh"
`default_nettype none

bind bgl_brownout_ctrl bgl_brownout_ctrl_sva chk (.sys_clk, .rst_n, .wb_cyc_i, .wb_stb_i,
    .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .gainAtten,
    .controllerState, .lvl2DwellUs, .lvl2AttackStep);

module tb_bgl_brownout_ctrl;
    timeunit 1ns;
    timeprecision 1ps;

    // ****
    // Signals and tables
    // ****
    logic        sys_clk, rst_n, cyc, stb, we, ack;
    logic [9:0]  adr;
    logic [3:0]  sel;
    logic [31:0] datW, datR;
    logic [7:0]  supply;
    logic [18:0] gain, l2Step;
    logic [3:0]  state;
    logic [13:0] dwell;
    int          numErrors, nChecks, n;
    localparam logic [7:0] IDX [8] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h30, 8'h31, 8'h10};
    localparam logic [7:0] RST [8] = '{8'h06, 8'h2C, 8'h4C, 8'h20, 8'h02, 8'h10, 8'h00, 8'h00};
    localparam logic [7:0] ONE [8] = '{8'hFE, 8'hFF, 8'hFF, 8'hF0, 8'hFE, 8'h00, 8'h00, 8'h00};
    localparam logic [7:0] THR [4] = '{8'h38, 8'h39, 8'hD2, 8'hD3};
    localparam logic [7:0] SRC [4] = '{8'h11, 8'h11, 8'h13, 8'h13};
    localparam logic       TRIP [4] = '{1'b1, 1'b0, 1'b1, 1'b0};

    // Short ms so release timing fits the run
    bgl_brownout_ctrl #(.MS_CYCLES(25)) uut (.sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(cyc),
        .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(datW),
        .wb_dat_o(datR), .wb_ack_o(ack), .supplyCode(supply), .gainAtten(gain),
        .controllerState(state), .lvl2DwellUs(dwell), .lvl2AttackStep(l2Step));

    // 25 MHz clock
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    // ****
    // Tasks
    // ****
    task automatic giveVerdict();
        $display("Checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        nChecks++;
        if (got !== exp) begin
            numErrors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Classic cycle; request held until ack is sampled
    task automatic busOp(input logic w, input logic [7:0] idx, input logic [7:0] d,
                         output logic [31:0] q);
        int k;
        k = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        datW <= {24'h00_0000, d};
        @(posedge sys_clk);
        while (ack !== 1'b1) begin
            k++;
            if (k > 20) begin
                check("bus ack", 1, 0);
                giveVerdict();
            end
            @(posedge sys_clk);
        end
        q = datR;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        busOp(1'b1, idx, d, q);
    endtask

    task automatic rdChk(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] q;
        busOp(1'b0, idx, 8'h00, q);
        check(what, exp, q);
    endtask

    // Cycles until gain shows a value, bounded
    task automatic waitGain(input logic [18:0] exp, output int c);
        c = 0;
        while (gain !== exp) begin
            c++;
            if (c > 2000) begin
                check("gain wait", exp, gain);
                giveVerdict();
            end
            @(posedge sys_clk);
        end
    endtask

    // ****
    // Main sequence
    // ****
    initial begin
        {rst_n, cyc, stb, we} = 4'h0;
        adr = 10'h000;
        sel = 4'hF;
        datW = 32'h0000_0000;
        supply = 8'hFF;
        numErrors = 0;
        nChecks = 0;
        repeat (4) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        for (int i = 0; i < 8; i++) rdChk("reset value", IDX[i], RST[i]);
        for (int i = 0; i < 8; i++) begin
            if (i == 5) continue;
            wr(IDX[i], 8'hFF);
            rdChk("masked value", IDX[i], ONE[i]);
        end
        check("dwell top", 8000, dwell);
        check("step top", 60000, l2Step);
        // Level-3 attack, infinite hold, snapshot, release
        wr(8'h20, 8'h02);
        wr(8'h21, 8'h02);
        wr(8'h22, 8'h30);
        wr(8'h23, 8'hE0);
        supply <= 8'h20;
        wr(8'h30, 8'h11);
        waitGain(19'd5000, n);
        waitGain(19'd10000, n);
        check("attack interval", `BGL_ATK_BASE_CYC, n);
        waitGain(19'd20000, n);
        repeat (2) @(posedge sys_clk); // Hold entry and state shadow lag two edges
        rdChk("hold state", 8'h23, 8'hE5);
        supply <= 8'h40;
        repeat (300) @(posedge sys_clk);
        check("infinite hold", 20000, gain);
        wr(8'h30, 8'h19);
        wr(8'h30, 8'h1D);
        waitGain(19'd15000, n);
        waitGain(19'd10000, n);
        check("release interval", 125, n);
        rdChk("frozen state", 8'h23, 8'hE5);
        check("state port", 5, state);
        rdChk("clear self", 8'h30, 8'h19);
        waitGain(19'd0, n);
        wr(8'h30, 8'h11);
        rdChk("idle state", 8'h23, 8'hE0);
        // Level disable, then global enable off
        wr(8'h23, 8'h10);
        supply <= 8'h00;
        repeat (300) @(posedge sys_clk);
        check("level skipped", 0, gain);
        wr(8'h23, 8'h00);
        waitGain(19'd5000, n);
        wr(8'h30, 8'h10);
        @(posedge sys_clk); // Enable lands on the ack edge, gain clears one edge later
        check("global off", 0, gain);
        // Threshold limits for both sources
        for (int i = 0; i < 4; i++) begin
            wr(8'h22, THR[i]);
            wr(8'h30, SRC[i]);
            repeat (200) @(posedge sys_clk);
            check("threshold trip", TRIP[i], gain != 0);
            wr(8'h30, 8'h10);
        end
        // Spread of level-2 codes for the decode checks
        for (int c = 0; c < 8; c++) wr(8'h24, 8'(c * 37));
        repeat (2) @(posedge sys_clk);
        giveVerdict();
    end
endmodule

`default_nettype wire
